// *** rtl/matg_pkg.sv ***
// package for the melody and alarm tone generator
package matg_pkg;
    // ==============================
    // register offsets
    localparam logic [11:0] ADDR_ALARM_PATTERN = 12'h330;
    localparam logic [11:0] ADDR_TONE_CONTROL = 12'h331;
    localparam logic [11:0] ADDR_TONE_FREQ_LOW = 12'h332;
    localparam logic [11:0] ADDR_TONE_FREQ_HIGH = 12'h333;
    localparam logic [11:0] ADDR_TONE_IRQ_ENABLE = 12'h334;
    localparam logic [11:0] ADDR_TONE_IRQ_STATUS = 12'h335;
    // ==============================
    // field positions
    localparam int CTRL_OUTSEL_BIT = 0;
    localparam int CTRL_INVERT_BIT = 5;
    localparam int CTRL_FC_LO_BIT = 6;
    localparam int FREQH_RUN_BIT = 7;
    localparam int NUM_IRQ = 5;
    // ==============================
    // reset values and masks
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'he1;
    localparam logic [7:0] FREQH_WMASK = 8'h8f;
    localparam logic [7:0] IRQEN_WMASK = 8'h1f;
    // ==============================
    // timing: alarm base tick period and pattern step period
    localparam int ALARM_HALF_NS = 122070;
    localparam int CLK_NS = 20;
    localparam int ALARM_HALF_CYC = ALARM_HALF_NS / CLK_NS;
    localparam int PATTERN_STEP_CYC = 8192;
    // ==============================
    // free-running counter control codes
    typedef enum logic [1:0] {
        MATG_FC_HOLD = 2'b00,
        MATG_FC_RESTART = 2'b01,
        MATG_FC_CLEAR = 2'b10,
        MATG_FC_CLRSTART = 2'b11
    } matg_fc_t;
    // register bus request bundle
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } matg_bus_t;
endpackage

// *** rtl/matg_divider.sv ***
// enable divider producing one-cycle ticks
`timescale 1ns/1ps
module matg_divider #(
    parameter int CW = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // control
    input wire logic run,
    input wire logic clear,
    input wire logic [CW-1:0] limit,
    // tick
    output logic tick
);
    import matg_pkg::*;
    logic [CW-1:0] cnt_q, cnt_d;
    logic tick_d;

    // count up to limit, then wrap and pulse
    always_comb begin
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (clear) begin
            cnt_d = '0;
        end else if (run) begin
            if (cnt_q >= limit) begin
                cnt_d = '0;
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    // register state
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick <= tick_d;
        end
    end
endmodule

// *** rtl/matg_melody.sv ***
// melody counter: toggles tone at programmed 12-bit count
`timescale 1ns/1ps
module matg_melody (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // control
    input wire logic run,
    input wire logic [11:0] freq,
    // tone
    output logic tone
);
    import matg_pkg::*;
    logic [11:0] cnt_q, cnt_d;
    logic tone_q, tone_d;

    // reload and toggle on match, stop clears
    always_comb begin
        cnt_d = cnt_q;
        tone_d = tone_q;
        if (!run) begin
            cnt_d = '0; // RL5
            tone_d = 1'b0;
        end else if (cnt_q >= freq) begin
            cnt_d = '0; // RL8
            tone_d = ~tone_q;
        end else begin
            cnt_d = cnt_q + 12'h001;
        end
    end

    // register state
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
            tone_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tone_q <= tone_d;
        end
    end
    assign tone = tone_q;

    a_melody_stop_clears: assert property (@(posedge mclk) disable iff (!rstn)
        !run |=> (cnt_q == 12'h000) && !tone_q) // RL5
        else $error("melody counter not cleared while stopped");
    a_melody_toggle_match: assert property (@(posedge mclk) disable iff (!rstn)
        run && cnt_q >= freq |=> tone_q != $past(tone_q) && cnt_q == 12'h000) // RL8
        else $error("melody tone did not toggle on match");
endmodule

// *** rtl/matg_top.sv ***
// melody and alarm tone generator with register port and interrupt
`timescale 1ns/1ps

// Function
// RL1: counter control: 00 hold, 01 restart, 10 clear, 11 clear and start.
// RL2: invert bit set outputs the alarm signal inverted, else unchanged.
// RL3: select bit 0 routes alarm tone, 1 routes melody tone.
// RL4: melody frequency is 12 bits: low byte plus high register low nibble.
// RL5: run bit 0 stops and clears melody counter, 1 starts; resets to 0.
// RL6: eight-bit read/write alarm pattern register, reset zero, gates alarm tone.
// RL7: five alarm interrupt sources, each gated by its own enable bit.
// RL8: running melody counter toggles tone at programmed value, reloads, continues.
module matg_top #(
    parameter int PATTERN_STEP = matg_pkg::PATTERN_STEP_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // register port
    input wire logic [11:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    // tone and interrupt
    output logic toneOut,
    output logic irq
);
    import matg_pkg::*;

    // ==============================
    // register file
    matg_bus_t bus;
    logic [7:0] pattern_q, pattern_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] freqL_q, freqL_d;
    logic [7:0] freqH_q, freqH_d;
    logic [7:0] irqEn_q, irqEn_d;
    logic [4:0] irqSt_q, irqSt_d;
    logic [7:0] rdata_d;
    logic [4:0] irqEvent;
    logic fcCmd;

    assign bus = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

    // register writes; status is write-one-to-clear, set wins
    always_comb begin
        pattern_d = pattern_q;
        ctrl_d = ctrl_q;
        freqL_d = freqL_q;
        freqH_d = freqH_q;
        irqEn_d = irqEn_q;
        irqSt_d = irqSt_q;
        fcCmd = 1'b0;
        if (bus.wr) begin
            case (bus.addr)
                ADDR_ALARM_PATTERN: pattern_d = bus.wdata; // RL6
                ADDR_TONE_CONTROL: begin
                    ctrl_d = bus.wdata & CTRL_WMASK;
                    fcCmd = 1'b1; // RL1
                end
                ADDR_TONE_FREQ_LOW: freqL_d = bus.wdata; // RL4
                ADDR_TONE_FREQ_HIGH: freqH_d = bus.wdata & FREQH_WMASK; // RL4
                ADDR_TONE_IRQ_ENABLE: irqEn_d = bus.wdata & IRQEN_WMASK; // RL7
                ADDR_TONE_IRQ_STATUS: irqSt_d = irqSt_q & ~bus.wdata[4:0];
                default: begin
                end
            endcase
        end
        irqSt_d = irqSt_d | irqEvent;
    end

    // read mux, data valid the cycle after the strobe
    always_comb begin
        rdata_d = 8'h00;
        if (bus.rd) begin
            case (bus.addr)
                ADDR_ALARM_PATTERN: rdata_d = pattern_q;
                ADDR_TONE_CONTROL: rdata_d = ctrl_q;
                ADDR_TONE_FREQ_LOW: rdata_d = freqL_q;
                ADDR_TONE_FREQ_HIGH: rdata_d = freqH_q;
                ADDR_TONE_IRQ_ENABLE: rdata_d = irqEn_q;
                ADDR_TONE_IRQ_STATUS: rdata_d = {3'h0, irqSt_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // register state
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pattern_q <= RESET_BYTE; // RL6
            ctrl_q <= RESET_BYTE;
            freqL_q <= RESET_BYTE;
            freqH_q <= RESET_BYTE; // RL5
            irqEn_q <= RESET_BYTE;
            irqSt_q <= 5'h00;
            regRdata <= 8'h00;
        end else begin
            pattern_q <= pattern_d;
            ctrl_q <= ctrl_d;
            freqL_q <= freqL_d;
            freqH_q <= freqH_d;
            irqEn_q <= irqEn_d;
            irqSt_q <= irqSt_d;
            regRdata <= rdata_d;
        end
    end

    // interrupt level: any enabled sticky status bit
    assign irq = |(irqSt_q & irqEn_q[4:0]); // RL7

    // ==============================
    // free-running counter
    typedef enum logic [0:0] {
        MATG_FR_STOP = 1'b0,
        MATG_FR_RUN = 1'b1
    } matg_frst_t;
    matg_frst_t frState_q, frState_d;
    matg_fc_t fcCode;
    logic frClear;
    logic [7:0] freeCnt_q, freeCnt_d;
    logic stepTick, alarmTick;

    assign fcCode = matg_fc_t'(bus.wdata[CTRL_FC_LO_BIT +: 2]);

    // decode control code at the write
    always_comb begin
        frState_d = frState_q;
        frClear = 1'b0;
        if (fcCmd) begin
            case (fcCode)
                MATG_FC_HOLD: frState_d = MATG_FR_STOP; // RL1
                MATG_FC_RESTART: frState_d = MATG_FR_RUN; // RL1
                MATG_FC_CLEAR: begin
                    frState_d = MATG_FR_STOP; // RL1
                    frClear = 1'b1;
                end
                MATG_FC_CLRSTART: begin
                    frState_d = MATG_FR_RUN; // RL1
                    frClear = 1'b1;
                end
                default: frState_d = MATG_FR_STOP;
            endcase
        end
    end

    // alarm step counter advances on step ticks
    always_comb begin
        freeCnt_d = freeCnt_q;
        if (frClear) begin
            freeCnt_d = 8'h00;
        end else if (frState_q == MATG_FR_RUN && stepTick) begin
            freeCnt_d = freeCnt_q + 8'h01;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            frState_q <= MATG_FR_STOP;
            freeCnt_q <= 8'h00;
        end else begin
            frState_q <= frState_d;
            freeCnt_q <= freeCnt_d;
        end
    end

    // pattern step timebase
    matg_divider #(.CW(16)) uStep (
        .mclk(mclk),
        .rstn(rstn),
        .run(frState_q == MATG_FR_RUN),
        .clear(frClear),
        .limit(16'(PATTERN_STEP - 1)),
        .tick(stepTick)
    );

    // alarm carrier timebase
    matg_divider #(.CW(16)) uCarrier (
        .mclk(mclk),
        .rstn(rstn),
        .run(1'b1),
        .clear(1'b0),
        .limit(16'(ALARM_HALF_CYC - 1)),
        .tick(alarmTick)
    );

    // ==============================
    // tone generation
    logic carrier_q, carrier_d;
    logic [2:0] step;
    logic patternBit;
    logic alarmRaw, alarmTone, melodyTone, tone_d;
    logic [11:0] melFreq;

    assign step = freeCnt_q[2:0];
    assign patternBit = pattern_q[step]; // RL6
    assign carrier_d = alarmTick ? ~carrier_q : carrier_q;
    assign alarmRaw = carrier_q & patternBit & (frState_q == MATG_FR_RUN);
    assign alarmTone = ctrl_q[CTRL_INVERT_BIT] ? ~alarmRaw : alarmRaw; // RL2
    assign melFreq = {freqH_q[3:0], freqL_q}; // RL4
    assign tone_d = ctrl_q[CTRL_OUTSEL_BIT] ? melodyTone : alarmTone; // RL3

    // a write of one to a status bit with no competing event
    sequence s_status_clear(int b);
        bus.wr && bus.addr == ADDR_TONE_IRQ_STATUS && bus.wdata[b] && !irqEvent[b];
    endsequence

    // interrupt events: end of each pattern step group
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IRQ; gi++) begin : gIrq
            assign irqEvent[gi] = stepTick && (frState_q == MATG_FR_RUN) && (freeCnt_q[gi:0] == '1);
            a_status_set: assert property (@(posedge mclk) disable iff (!rstn)
                irqEvent[gi] |=> irqSt_q[gi]) // RL7
                else $error("status bit not set by its event");
            a_status_clear: assert property (@(posedge mclk) disable iff (!rstn)
                s_status_clear(gi) |=> !irqSt_q[gi]) // RL7
                else $error("status bit not cleared by a one");
            a_status_keep: assert property (@(posedge mclk) disable iff (!rstn)
                irqSt_q[gi] && !(bus.wr && bus.addr == ADDR_TONE_IRQ_STATUS) |=> irqSt_q[gi]) // RL7
                else $error("status bit lost without a clear");
            a_irq_source: assert property (@(posedge mclk) disable iff (!rstn)
                irqSt_q[gi] && irqEn_q[gi] |-> irq) // RL7
                else $error("enabled status bit did not raise interrupt");
        end
    endgenerate

    matg_melody uMelody (
        .mclk(mclk),
        .rstn(rstn),
        .run(freqH_q[FREQH_RUN_BIT]), // RL5
        .freq(melFreq),
        .tone(melodyTone)
    );

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            carrier_q <= 1'b0;
            toneOut <= 1'b0;
        end else begin
            carrier_q <= carrier_d;
            toneOut <= tone_d;
        end
    end

    // ==============================
    // checks
    sequence s_ctrl_write(logic [1:0] code);
        bus.wr && bus.addr == ADDR_TONE_CONTROL && bus.wdata[7:6] == code;
    endsequence

    a_fc_hold_stop: assert property (@(posedge mclk) disable iff (!rstn)
        s_ctrl_write(2'b00) |=> frState_q == MATG_FR_STOP ##1 ($stable(freeCnt_q) || $past(frClear))) // RL1
        else $error("hold code did not stop counter");
    a_fc_clear_zero: assert property (@(posedge mclk) disable iff (!rstn)
        s_ctrl_write(2'b10) |=> freeCnt_q == 8'h00 && frState_q == MATG_FR_STOP) // RL1
        else $error("clear code did not clear counter");
    a_fc_clrstart_run: assert property (@(posedge mclk) disable iff (!rstn)
        s_ctrl_write(2'b11) |=> freeCnt_q == 8'h00 && frState_q == MATG_FR_RUN) // RL1
        else $error("clear and start failed");
    a_fc_restart_run: assert property (@(posedge mclk) disable iff (!rstn)
        s_ctrl_write(2'b01) |=> frState_q == MATG_FR_RUN) // RL1
        else $error("restart code did not run counter");
    a_tone_invert: assert property (@(posedge mclk) disable iff (!rstn)
        !ctrl_q[0] && $stable(ctrl_q) |=> toneOut == ($past(alarmRaw) ^ $past(ctrl_q[5]))) // RL2
        else $error("alarm inversion wrong");
    a_tone_select: assert property (@(posedge mclk) disable iff (!rstn)
        ctrl_q[0] |=> toneOut == $past(melodyTone)) // RL3
        else $error("melody not routed to output");
    a_freq_join: assert property (@(posedge mclk) disable iff (!rstn)
        bus.wr && bus.addr == ADDR_TONE_FREQ_HIGH |=> melFreq[11:8] == $past(bus.wdata[3:0])) // RL4
        else $error("high nibble not stored");
    a_pattern_write: assert property (@(posedge mclk) disable iff (!rstn)
        bus.wr && bus.addr == ADDR_ALARM_PATTERN |=> pattern_q == $past(bus.wdata)) // RL6
        else $error("pattern register not written");
    a_irq_gating: assert property (@(posedge mclk) disable iff (!rstn)
        irqEn_q[4:0] == 5'h00 |-> !irq) // RL7
        else $error("interrupt raised while all disabled");

    // named steps of the register, counter and tone checks
    sequence s_reg_read(logic [11:0] a);
        bus.rd && bus.addr == a;
    endsequence
    sequence s_step_run;
        frState_q == MATG_FR_RUN && stepTick && !frClear;
    endsequence
    sequence s_alarm_quiet;
        !ctrl_q[CTRL_OUTSEL_BIT] && !ctrl_q[CTRL_INVERT_BIT] && (frState_q == MATG_FR_STOP || pattern_q == 8'h00);
    endsequence
    sequence s_alarm_open;
        !ctrl_q[CTRL_OUTSEL_BIT] && !ctrl_q[CTRL_INVERT_BIT] && frState_q == MATG_FR_RUN && pattern_q == 8'hff;
    endsequence
    sequence s_melody_idle;
        !freqH_q[FREQH_RUN_BIT] ##1 ctrl_q[CTRL_OUTSEL_BIT];
    endsequence

    // register port: one-cycle answers, stored fields, reserved bits zero
    a_read_idle: assert property (@(posedge mclk) disable iff (!rstn)
        !bus.rd |=> regRdata == 8'h00) // RL6
        else $error("read data not zero outside a read");
    a_read_pattern: assert property (@(posedge mclk) disable iff (!rstn)
        s_reg_read(ADDR_ALARM_PATTERN) |=> regRdata == $past(pattern_q)) // RL6
        else $error("pattern read back wrong");
    a_freq_low_write: assert property (@(posedge mclk) disable iff (!rstn)
        bus.wr && bus.addr == ADDR_TONE_FREQ_LOW |=> melFreq[7:0] == $past(bus.wdata)) // RL4
        else $error("low frequency byte not stored");
    a_run_bit_write: assert property (@(posedge mclk) disable iff (!rstn)
        bus.wr && bus.addr == ADDR_TONE_FREQ_HIGH |=> freqH_q[FREQH_RUN_BIT] == $past(bus.wdata[FREQH_RUN_BIT])) // RL5
        else $error("melody run bit not stored");
    a_enable_write: assert property (@(posedge mclk) disable iff (!rstn)
        bus.wr && bus.addr == ADDR_TONE_IRQ_ENABLE |=> irqEn_q[4:0] == $past(bus.wdata[4:0])) // RL7
        else $error("interrupt enables not stored");
    a_fields_reserved: assert property (@(posedge mclk) disable iff (!rstn)
        ctrl_q[4:1] == 4'h0 && freqH_q[6:4] == 3'h0) // RL4
        else $error("reserved control or frequency bits set");
    a_enable_reserved: assert property (@(posedge mclk) disable iff (!rstn)
        irqEn_q[7:5] == 3'h0) // RL7
        else $error("reserved enable bits set");

    // free-running counter: steps on ticks, still while stopped
    a_step_advance: assert property (@(posedge mclk) disable iff (!rstn)
        s_step_run |=> freeCnt_q == $past(freeCnt_q) + 8'h01) // RL1
        else $error("running counter did not step on tick");
    a_stop_holds: assert property (@(posedge mclk) disable iff (!rstn)
        frState_q == MATG_FR_STOP && !frClear |=> $stable(freeCnt_q)) // RL1
        else $error("stopped counter moved");

    // tone path seen at the output
    a_alarm_quiet: assert property (@(posedge mclk) disable iff (!rstn)
        s_alarm_quiet |=> !toneOut) // RL6
        else $error("alarm tone present while muted");
    a_alarm_open: assert property (@(posedge mclk) disable iff (!rstn)
        s_alarm_open |=> toneOut == $past(carrier_q)) // RL6
        else $error("open pattern did not pass the carrier");
    a_invert_stopped: assert property (@(posedge mclk) disable iff (!rstn)
        ctrl_q[CTRL_INVERT_BIT] && !ctrl_q[CTRL_OUTSEL_BIT] && frState_q == MATG_FR_STOP |=> toneOut) // RL2
        else $error("inverted silent alarm not high");
    a_carrier_toggle: assert property (@(posedge mclk) disable iff (!rstn)
        alarmTick |=> carrier_q != $past(carrier_q)) // RL2
        else $error("carrier did not toggle on its tick");
    a_melody_idle: assert property (@(posedge mclk) disable iff (!rstn)
        s_melody_idle |=> !toneOut) // RL5
        else $error("stopped melody still on the output");
endmodule

// *** test/matg_top_test.sv ***
// self-checking bench for the melody and alarm tone generator
`timescale 1ns/1ps
module matg_top_test;
    import matg_pkg::*;
    // ==============================
    // stimulus and observed signals
    localparam int STEP = 4;
    localparam logic [11:0] ADDRS [6] = '{ADDR_ALARM_PATTERN, ADDR_TONE_CONTROL, ADDR_TONE_FREQ_LOW,
                                          ADDR_TONE_FREQ_HIGH, ADDR_TONE_IRQ_ENABLE, 12'h336};
    localparam logic [7:0] MASKS [6] = '{8'hff, CTRL_WMASK, 8'hff, FREQH_WMASK, IRQEN_WMASK, 8'h00};
    localparam logic [11:0] FREQS [3] = '{12'h000, 12'h002, 12'h103};
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [11:0] regAddr = 12'h000;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdata;
    logic toneOut;
    logic irq;
    logic rdPend = 1'b0;
    logic [7:0] expQ [$];
    logic [7:0] wv [6];
    int fail_count = 0;
    int n_compared = 0;
    int len;
    // ==============================
    // clock and device
    initial begin
        forever #10 mclk = ~mclk;
    end
    matg_top #(.PATTERN_STEP(STEP)) u_dut (.mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .toneOut(toneOut), .irq(irq));
    // ==============================
    // comparison and closing
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s saw %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ==============================
    // read data watcher: oldest note against the answer cycle
    always @(posedge mclk) begin
        rdPend <= regRd;
    end
    always @(negedge mclk) begin
        if (rdPend && expQ.size() > 0) begin
            check({8'h00, regRdata}, {8'h00, expQ.pop_front()}, "read data");
        end else if (!rdPend) begin
            check({8'h00, regRdata}, 16'h0000, "idle read data");
        end
    end
    // ==============================
    // register port cycles
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        expQ.push_back(exp);
        @(posedge mclk);
        regRd <= 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask
    // ==============================
    // tone level watching, bounded
    task automatic await_tone(input logic lvl);
        int k;
        k = 0;
        @(negedge mclk);
        while (toneOut !== lvl) begin
            @(negedge mclk);
            k++;
            if (k > 20000) begin
                fail_count++;
                $display("unexpected at %0t: tone wait ran out", $time);
                close_out();
            end
        end
    endtask
    task automatic run_len(input logic lvl, output int n);
        n = 0;
        while (toneOut === lvl && n < 20000) begin
            @(negedge mclk);
            n++;
        end
    endtask
    // ==============================
    // main sequence
    initial begin
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        wv[0] = 8'($urandom(13991));
        // reset values, status included
        foreach (ADDRS[i]) rd(ADDRS[i], RESET_BYTE);
        rd(ADDR_TONE_IRQ_STATUS, RESET_BYTE);
        $display("test reset values done");
        // random write and read back through the field masks
        foreach (ADDRS[i]) begin
            wv[i] = 8'($urandom());
            wr(ADDRS[i], wv[i]);
        end
        foreach (ADDRS[i]) rd(ADDRS[i], wv[i] & MASKS[i]);
        $display("test register access done");
        // invert and output select with a silent alarm
        wr(ADDR_TONE_FREQ_HIGH, 8'h00);
        wr(ADDR_ALARM_PATTERN, 8'h00);
        wr(ADDR_TONE_CONTROL, 8'h20);
        settle(3);
        check({15'h0, toneOut}, 16'h0001, "inverted alarm");
        wr(ADDR_TONE_CONTROL, 8'h00);
        settle(3);
        check({15'h0, toneOut}, 16'h0000, "plain alarm");
        wr(ADDR_TONE_CONTROL, 8'h21);
        settle(3);
        check({15'h0, toneOut}, 16'h0000, "melody selected");
        $display("test invert and select done");
        // melody half periods for several 12-bit settings, stopped while high
        foreach (FREQS[i]) begin
            wr(ADDR_TONE_FREQ_HIGH, 8'h00);
            wr(ADDR_TONE_FREQ_LOW, FREQS[i][7:0]);
            wr(ADDR_TONE_FREQ_HIGH, {4'h8, FREQS[i][11:8]});
            await_tone(1'b0);
            await_tone(1'b1);
            run_len(1'b1, len);
            check(16'(len), 16'(FREQS[i]) + 16'h1, "melody high run");
            run_len(1'b0, len);
            check(16'(len), 16'(FREQS[i]) + 16'h1, "melody low run");
            wr(ADDR_TONE_FREQ_HIGH, 8'h00);
            settle(3);
            check({15'h0, toneOut}, 16'h0000, "melody stopped");
        end
        settle(30);
        check({15'h0, toneOut}, 16'h0000, "melody stays stopped");
        $display("test melody done");
        // free-running counter codes seen through the sticky events
        wr(ADDR_TONE_IRQ_ENABLE, 8'h00);
        wr(ADDR_TONE_CONTROL, 8'hc0);
        wr(ADDR_TONE_IRQ_STATUS, 8'h1f);
        settle(40);
        rd(ADDR_TONE_IRQ_STATUS, 8'h07);
        wr(ADDR_TONE_CONTROL, 8'h00);
        wr(ADDR_TONE_IRQ_STATUS, 8'h1f);
        settle(200);
        rd(ADDR_TONE_IRQ_STATUS, 8'h00);
        wr(ADDR_TONE_CONTROL, 8'h40);
        settle(40);
        wr(ADDR_TONE_CONTROL, 8'h00);
        rd(ADDR_TONE_IRQ_STATUS, 8'h0f);
        // enables gate the level output, write one clears
        settle(2);
        check({15'h0, irq}, 16'h0000, "irq unmasked none");
        wr(ADDR_TONE_IRQ_ENABLE, 8'h10);
        settle(2);
        check({15'h0, irq}, 16'h0000, "irq other source");
        wr(ADDR_TONE_IRQ_ENABLE, 8'h08);
        settle(2);
        check({15'h0, irq}, 16'h0001, "irq raised");
        wr(ADDR_TONE_IRQ_STATUS, 8'h08);
        settle(2);
        check({15'h0, irq}, 16'h0000, "irq cleared");
        rd(ADDR_TONE_IRQ_STATUS, 8'h07);
        // clear then restart counts again from zero
        wr(ADDR_TONE_CONTROL, 8'h80);
        wr(ADDR_TONE_IRQ_STATUS, 8'h1f);
        wr(ADDR_TONE_CONTROL, 8'h40);
        settle(40);
        wr(ADDR_TONE_CONTROL, 8'h00);
        rd(ADDR_TONE_IRQ_STATUS, 8'h07);
        settle(4);
        $display("test counter and interrupts done");
        // open pattern passes the carrier half period, an empty pattern mutes it
        wr(ADDR_ALARM_PATTERN, 8'hff);
        wr(ADDR_TONE_CONTROL, 8'hc0);
        await_tone(1'b0);
        await_tone(1'b1);
        run_len(1'b1, len);
        check(16'(len), 16'(ALARM_HALF_CYC), "alarm high run");
        wr(ADDR_ALARM_PATTERN, 8'h00);
        settle(3);
        check({15'h0, toneOut}, 16'h0000, "alarm muted by pattern");
        wr(ADDR_TONE_CONTROL, 8'he0);
        settle(3);
        check({15'h0, toneOut}, 16'h0001, "muted alarm inverted");
        $display("test alarm pattern done");
        close_out();
    end
endmodule
